// file: bfeu_pkg.sv
// Purpose: constants and types for the bit field and extend unit
// Assumes: 32-bit datapath, one result per accepted request
// Notes:   operation codes are local to this unit
package bfeu_pkg;
    localparam int DATA_W  = 32;
    localparam int POS_W   = 5;
    localparam int WID_W   = 6;
    localparam int ROT_W   = 2;
    localparam int REG_W   = 4;
    localparam int BYTE_W  = 8;
    localparam int HALF_W  = 16;

    typedef enum logic [3:0] {
        BFEU_NOP_OP                   = 4'h0,
        BFEU_FIELD_CLEAR_OP           = 4'h1,
        BFEU_FIELD_INSERT_OP          = 4'h2,
        BFEU_SIGNED_FIELD_EXTRACT_OP  = 4'h3,
        BFEU_UNSIGNED_FIELD_EXTRACT_OP = 4'h4,
        BFEU_SIGNED_BYTE_EXTEND_OP    = 4'h5,
        BFEU_SIGNED_HALF_EXTEND_OP    = 4'h6,
        BFEU_ZERO_BYTE_EXTEND_OP      = 4'h7,
        BFEU_ZERO_HALF_EXTEND_OP      = 4'h8
    } bfeu_op_t;

    typedef struct packed {
        bfeu_op_t            op;
        logic                cond_pass;
        logic [REG_W-1:0]    dest_idx;
        logic [DATA_W-1:0]   source_register;
        logic [DATA_W-1:0]   dest_old;
        logic [POS_W-1:0]    lsb;
        logic [WID_W-1:0]    width;
        logic [ROT_W-1:0]    rot;
    } bfeu_req_t;

    typedef struct packed {
        logic                wr_en;
        logic [REG_W-1:0]    dest_idx;
        logic [DATA_W-1:0]   data;
    } bfeu_res_t;
endpackage : bfeu_pkg

// file: bfeu_unit.sv
// Purpose: one-cycle bit field and extend datapath
// Assumes: operands read by the core before the request
// Notes:   flags output is never asserted; result registered
`timescale 1ns/1ns
module bfeu_unit (
    input  wire logic               core_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               req_valid_in,
    input  wire bfeu_pkg::bfeu_req_t req_in,
    output logic                    res_valid_out,
    output bfeu_pkg::bfeu_res_t     res_out,
    output logic                    flags_we_out
);
    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_r;
    logic rst_s2_r;
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    // assertion is immediate, release waits two edges so no flop sees a ragged edge
    wire rst_n = rst_s2_r;

    // ------------------------------------------------------------
    // field masks
    // ------------------------------------------------------------
    localparam int DW = bfeu_pkg::DATA_W;
    wire [DW-1:0] ones      = {DW{1'b1}};
    // width 32 would overflow a shift of one, so shift all-ones down
    wire [5:0]    inv_w     = 6'(DW) - req_in.width;
    wire [DW-1:0] low_mask  = ones >> inv_w;
    // lsb plus width past 32 is undefined; the shift simply drops the overflow
    wire [DW-1:0] fld_mask  = low_mask << req_in.lsb;
    wire [DW-1:0] src       = req_in.source_register;
    wire [DW-1:0] old       = req_in.dest_old;

    wire [DW-1:0] clr_val   = old & ~fld_mask;
    wire [DW-1:0] ins_val   = clr_val | ((src << req_in.lsb) & fld_mask);
    wire [DW-1:0] ufx_val   = (src >> req_in.lsb) & low_mask;
    wire [5:0]    top_pos   = 6'(req_in.width) - 6'd1;
    wire          fx_sign   = ufx_val[top_pos[4:0]];
    wire [DW-1:0] sfx_val   = ufx_val | (fx_sign ? ~low_mask : '0);

    // ------------------------------------------------------------
    // rotate and extend
    // ------------------------------------------------------------
    wire [4:0]    rot_amt   = {req_in.rot, 3'b000};
    // a zero rotate shifts the wrap term by 32, which leaves it empty as wanted
    wire [DW-1:0] rot_val   = (src >> rot_amt) | (src << (6'(DW) - 6'(rot_amt)));
    wire [7:0]    rb        = rot_val[bfeu_pkg::BYTE_W-1:0];
    wire [15:0]   rh        = rot_val[bfeu_pkg::HALF_W-1:0];
    wire [DW-1:0] sxb_val   = {{24{rb[7]}}, rb};
    wire [DW-1:0] zxb_val   = {24'h00_0000, rb};
    wire [DW-1:0] sxh_val   = {{16{rh[15]}}, rh};
    wire [DW-1:0] zxh_val   = {16'h0000, rh};

    // ------------------------------------------------------------
    // operation decode and result select
    // ------------------------------------------------------------
    wire          op_clr  = (req_in.op == bfeu_pkg::BFEU_FIELD_CLEAR_OP);
    wire          op_ins  = (req_in.op == bfeu_pkg::BFEU_FIELD_INSERT_OP);
    wire          op_sfx  = (req_in.op == bfeu_pkg::BFEU_SIGNED_FIELD_EXTRACT_OP);
    wire          op_ufx  = (req_in.op == bfeu_pkg::BFEU_UNSIGNED_FIELD_EXTRACT_OP);
    wire          op_sxb  = (req_in.op == bfeu_pkg::BFEU_SIGNED_BYTE_EXTEND_OP);
    wire          op_sxh  = (req_in.op == bfeu_pkg::BFEU_SIGNED_HALF_EXTEND_OP);
    wire          op_zxb  = (req_in.op == bfeu_pkg::BFEU_ZERO_BYTE_EXTEND_OP);
    wire          op_zxh  = (req_in.op == bfeu_pkg::BFEU_ZERO_HALF_EXTEND_OP);
    // other codes fall through with no result and no write
    wire          is_op   = op_clr | op_ins | op_sfx | op_ufx |
                            op_sxb | op_sxh | op_zxb | op_zxh;
    // flat and-or select; the decodes are exclusive so no priority is needed
    wire [DW-1:0] res_val = ({DW{op_clr}} & clr_val) |
                            ({DW{op_ins}} & ins_val) |
                            ({DW{op_sfx}} & sfx_val) |
                            ({DW{op_ufx}} & ufx_val) |
                            ({DW{op_sxb}} & sxb_val) |
                            ({DW{op_sxh}} & sxh_val) |
                            ({DW{op_zxb}} & zxb_val) |
                            ({DW{op_zxh}} & zxh_val);

    // ------------------------------------------------------------
    // result register
    // ------------------------------------------------------------
    wire                 acc_nxt = req_valid_in & is_op;
    // data is still computed when the write is suppressed
    wire                 wr_nxt  = acc_nxt & req_in.cond_pass;
    bfeu_pkg::bfeu_res_t res_r;
    logic                vld_r;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            vld_r <= 1'b0;
            res_r <= '0;
        end else begin
            vld_r <= acc_nxt;
            res_r <= '{wr_en: wr_nxt, dest_idx: req_in.dest_idx, data: res_val};
        end
    end
    assign res_valid_out = vld_r;
    assign res_out       = res_r;

    // ------------------------------------------------------------
    // condition flags
    // ------------------------------------------------------------
    // no operation here owns the flags; the port still leaves from a flop
    logic flags_we_r;
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flags_we_r <= 1'b0;
        end else begin
            flags_we_r <= 1'b0;
        end
    end
    assign flags_we_out  = flags_we_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // mask and rotate are checked against plain arithmetic, not the datapath wires
    mask_width_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.width inside {[6'd1:6'd32]}) |->
        (low_mask == 32'((64'h1 << req_in.width) - 64'h1)))
        else $error("field mask wrong");
    clear_keeps_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_FIELD_CLEAR_OP) |=>
        ((res_out.data & $past(fld_mask)) == '0 &&
         (res_out.data & ~$past(fld_mask)) == ($past(old) & ~$past(fld_mask))))
        else $error("field clear wrong");
    insert_field_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_FIELD_INSERT_OP) |=>
        (((res_out.data >> $past(req_in.lsb)) & $past(low_mask)) ==
         ($past(src) & $past(low_mask))))
        else $error("field insert wrong");
    insert_keeps_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_FIELD_INSERT_OP) |=>
        ((res_out.data & ~$past(fld_mask)) == ($past(old) & ~$past(fld_mask))))
        else $error("field insert disturbs other bits");
    sext_top_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_SIGNED_FIELD_EXTRACT_OP) |=>
        (res_out.data[31] == $past(fx_sign)))
        else $error("signed extract sign wrong");
    sext_low_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_SIGNED_FIELD_EXTRACT_OP) |=>
        ((res_out.data & $past(low_mask)) ==
         (($past(src) >> $past(req_in.lsb)) & $past(low_mask))))
        else $error("signed extract field wrong");
    sext_value_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_SIGNED_FIELD_EXTRACT_OP) |=>
        (res_out.data == 32'($signed($past(src) << (6'd32 - 6'($past(req_in.lsb))
            - $past(req_in.width))) >>> (6'd32 - $past(req_in.width)))))
        else $error("signed extract value wrong");
    uext_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_UNSIGNED_FIELD_EXTRACT_OP) |=>
        ((res_out.data & ~$past(low_mask)) == '0))
        else $error("unsigned extract high bits");
    uext_value_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_UNSIGNED_FIELD_EXTRACT_OP) |=>
        (res_out.data == (($past(src) >> $past(req_in.lsb)) &
                          32'((64'h1 << $past(req_in.width)) - 64'h1))))
        else $error("unsigned extract value wrong");
    rot_byte_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_ZERO_BYTE_EXTEND_OP) |=>
        (res_out.data == {24'h00_0000, 8'($past(src) >> {$past(req_in.rot), 3'b000})}))
        else $error("byte rotate wrong");
    sbyte_rot_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_SIGNED_BYTE_EXTEND_OP) |=>
        (res_out.data[7:0] == 8'({$past(src), $past(src)} >> {$past(req_in.rot), 3'b000})))
        else $error("signed byte rotate wrong");
    half_rot_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_ZERO_HALF_EXTEND_OP) |=>
        (res_out.data[15:0] == 16'({$past(src), $past(src)} >> {$past(req_in.rot), 3'b000})))
        else $error("half rotate wrong");
    sbyte_ext_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_SIGNED_BYTE_EXTEND_OP) |=>
        (res_out.data[31:8] == {24{res_out.data[7]}}))
        else $error("signed byte extend wrong");
    zbyte_high_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_ZERO_BYTE_EXTEND_OP) |=>
        (res_out.data[31:8] == 24'h00_0000))
        else $error("zero byte extend high bits");
    shalf_ext_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_SIGNED_HALF_EXTEND_OP) |=>
        (res_out.data[31:16] == {16{res_out.data[15]}}))
        else $error("signed half extend wrong");
    zhalf_high_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && req_in.op == bfeu_pkg::BFEU_ZERO_HALF_EXTEND_OP) |=>
        (res_out.data[31:16] == 16'h0000))
        else $error("zero half extend high bits");
    no_flags_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        res_valid_out |-> !flags_we_out)
        else $error("flags written");
    one_result_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        1'b1 |=> (res_valid_out == $past(req_valid_in && is_op)))
        else $error("result pulse does not match request");
    cond_fail_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && is_op && !req_in.cond_pass) |=> (res_valid_out && !res_out.wr_en))
        else $error("write not suppressed");
    cond_pass_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && is_op && req_in.cond_pass) |=> (res_valid_out && res_out.wr_en))
        else $error("passing write dropped");
    dest_keep_a: assert property (@(posedge core_clk_in) disable iff (!rst_n)
        (req_valid_in && is_op) |=> (res_out.dest_idx == $past(req_in.dest_idx)))
        else $error("destination index wrong");

    // ------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------
    // full-word fields, negative extracts, widest rotate, top-bit clear, failed condition
    cov_ins_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
        req_valid_in && req_in.op == bfeu_pkg::BFEU_FIELD_INSERT_OP && req_in.width == 6'd32);
    cov_sfx_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
        req_valid_in && req_in.op == bfeu_pkg::BFEU_SIGNED_FIELD_EXTRACT_OP && fx_sign);
    cov_rot_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
        req_valid_in && req_in.op == bfeu_pkg::BFEU_SIGNED_HALF_EXTEND_OP && req_in.rot == 2'd3);
    cov_clr_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
        req_valid_in && req_in.op == bfeu_pkg::BFEU_FIELD_CLEAR_OP && req_in.lsb == 5'd31);
    cov_fail_c: cover property (@(posedge core_clk_in) disable iff (!rst_n)
        req_valid_in && is_op && !req_in.cond_pass);
endmodule : bfeu_unit

// file: bfeu_unit_tb.sv
// Purpose: self-check of the bit field and extend unit with random and edge cases
// Assumes: one result per taken request, results come back in request order
// Notes:   expected data comes from a bench-side reference, never from the unit
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin err_count++; \
    $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module bfeu_unit_tb;
    logic                core_clk_in  = 1'b0;
    logic                rst_n_in     = 1'b0;
    logic                req_valid_in = 1'b0;
    bfeu_pkg::bfeu_req_t req_in       = '0;
    logic                res_valid_out;
    bfeu_pkg::bfeu_res_t res_out;
    logic                flags_we_out;
    bfeu_pkg::bfeu_res_t exp_q[$];
    bfeu_pkg::bfeu_res_t exp_r;
    int                  err_count    = 0;
    int                  checks       = 0;
    // indices at and above this belong to the stack pointer and pc
    localparam int       GP_REGS      = 13;

    always #2 core_clk_in = ~core_clk_in;

    bfeu_unit bfeu_unit_i (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .req_valid_in  (req_valid_in),
        .req_in        (req_in),
        .res_valid_out (res_valid_out),
        .res_out       (res_out),
        .flags_we_out  (flags_we_out)
    );

    // ----------------------------------------
    // reference and stimulus
    // ----------------------------------------
    function automatic logic [31:0] ref_data(bfeu_pkg::bfeu_req_t r);
        logic [63:0] m;
        logic [31:0] fm;
        logic [31:0] f;
        logic [31:0] rr;
        m  = (64'h1 << r.width) - 64'h1;
        fm = m[31:0] << r.lsb;
        f  = (r.source_register >> r.lsb) & m[31:0];
        rr = 32'({r.source_register, r.source_register} >> (r.rot * 8));
        case (r.op)
            bfeu_pkg::BFEU_FIELD_CLEAR_OP: return r.dest_old & ~fm;
            bfeu_pkg::BFEU_FIELD_INSERT_OP:
                return (r.dest_old & ~fm) | ((r.source_register << r.lsb) & fm);
            bfeu_pkg::BFEU_SIGNED_FIELD_EXTRACT_OP:
                return f[r.width-1] ? (f | ~m[31:0]) : f;
            bfeu_pkg::BFEU_UNSIGNED_FIELD_EXTRACT_OP: return f;
            bfeu_pkg::BFEU_SIGNED_BYTE_EXTEND_OP: return {{24{rr[7]}}, rr[7:0]};
            bfeu_pkg::BFEU_SIGNED_HALF_EXTEND_OP: return {{16{rr[15]}}, rr[15:0]};
            bfeu_pkg::BFEU_ZERO_BYTE_EXTEND_OP: return {24'h00_0000, rr[7:0]};
            default: return {16'h0000, rr[15:0]};
        endcase
    endfunction : ref_data

    // first eight requests walk every op but NOP, the fourth with valid low; lsb/width edges on two of every five
    task automatic send(input int i);
        bfeu_pkg::bfeu_req_t r;
        logic                v;
        r.op = bfeu_pkg::bfeu_op_t'((i < 8) ? i + 1 : 1 + $urandom % 8);
        if (i % 11 == 10) r.op = bfeu_pkg::bfeu_op_t'(4'h9 + 4'($urandom % 7));
        if (i % 13 == 12) r.op = bfeu_pkg::BFEU_NOP_OP;
        r.lsb = (i % 5 == 0) ? 5'h1f : (i % 5 == 1) ? 5'h00 : 5'($urandom % 32);
        r.width = (i % 5 == 0) ? 6'h01 : (i % 5 == 1) ? 6'h20
                : 6'(1 + $urandom % (32 - r.lsb));
        r.cond_pass = ($urandom % 4) != 0;
        r.dest_idx = 4'($urandom % GP_REGS);
        r.source_register = $urandom;
        r.dest_old = $urandom;
        r.rot = 2'($urandom);
        v = (i % 7 != 3);
        req_valid_in = v;
        req_in = r;
        if (v && r.op inside {[4'h1:4'h8]}) exp_q.push_back({r.cond_pass, r.dest_idx, ref_data(r)});
    endtask : send

    task automatic conclude();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // ----------------------------------------
    // monitor, sequence and watchdog
    // ----------------------------------------
    always @(negedge core_clk_in) begin
        if (rst_n_in) begin
            `CHK("flags_we", 1'b0, flags_we_out)
            if (res_valid_out !== 1'b0) begin
                exp_r = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
                `CHK("result", exp_r, res_out)
            end
        end
    end

    initial begin
        void'($urandom(32'h9ed5));
        repeat (3) @(posedge core_clk_in);
        #1 rst_n_in = 1'b1;
        repeat (3) @(posedge core_clk_in);
        for (int i = 0; i < 400; i++) begin
            #1;
            send(i);
            @(posedge core_clk_in);
        end
        #1 req_valid_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        `CHK("pending", 0, exp_q.size())
        conclude();
    end

    initial begin
        #20000;
        err_count++;
        conclude();
    end
endmodule : bfeu_unit_tb
